/* hdl/fieldbus_slave_io_map.sv */
// Cyclic I/O word mapper between fieldbus frames and slave registers.
`include "fb_io_cfg.svh"
`default_nettype none
module fieldbus_slave_io_map
    import fb_io_pkg::*;
#(
    parameter int MAX_WORDS = 13,
    parameter int ENTRY_CYCLES = `FB_ENTRY_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_long_frame,
    input wire logic i_rx_valid,
    input wire logic i_rx_first,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_end,
    input wire logic i_tx_start,
    input wire logic [7:0] i_tx_scan_counter,
    input wire logic [16*MAX_WORDS-1:0] i_tx_data,
    input wire logic i_sync_conditions,
    input wire logic i_cmd_received,
    input wire logic i_cmd_done,
    input wire logic i_warning,
    output logic [15:0] o_rx_scan_counter,
    output logic [15:0] o_link_control_word,
    output logic [15:0] o_slave_status_word,
    output logic [16*MAX_WORDS-1:0] o_rx_data,
    output logic o_tx_valid,
    output logic o_tx_last,
    output logic [7:0] o_tx_byte
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // True when a frame byte index falls in the data area
    function automatic logic in_data(input logic [4:0] idx,
                                     input logic [3:0] words);
        logic [5:0] lim;
        lim = 6'(`FB_DATA_BASE) + {1'b0, words, 1'b0};
        return (idx >= `FB_DATA_BASE) && ({1'b0, idx} < lim);
    endfunction

    lockstep_if lk ();
    logic [3:0] words; // Data words in this frame size
    logic [4:0] last_idx; // Final byte index of a frame
    logic [4:0] rx_idx; // Next receive byte index
    logic [4:0] cur_idx; // Index of the byte now arriving
    logic [3:0] rx_word; // Data word of the arriving byte
    logic [7:0] shadow_scan; // Scan byte of frame in flight
    logic shadow_inhibit; // Control flag of frame in flight
    io_word_t shadow_data [MAX_WORDS]; // Data of frame in flight
    io_word_t rx_data [MAX_WORDS]; // Committed data words
    logic cmd_busy; // Command in processing
    logic tx_busy; // Transmit in progress
    logic [4:0] tx_idx; // Byte being sent next
    logic [3:0] tx_word; // Data word of the byte sent next
    logic [7:0] tx_sel; // Byte chosen for transmit
    io_word_t tx_word_val; // Word feeding the data area
    io_word_t next_status; // Status word to present

    // ---------------------------------------------------------------
    // Frame geometry and selection
    // ---------------------------------------------------------------
    assign words = i_long_frame ? `FB_WORDS_LONG : `FB_WORDS_SHORT;
    assign last_idx = `FB_DATA_BASE + {words, 1'b0} - 5'h01;
    assign cur_idx = i_rx_first ? `FB_SCAN_BYTE : rx_idx;
    assign rx_word = 4'((cur_idx - `FB_DATA_BASE) >> 1);
    assign tx_word = 4'((tx_idx - `FB_DATA_BASE) >> 1);
    // Out-of-range words read as zero rather than wrapping
    assign tx_word_val = (32'(tx_word) < MAX_WORDS)
        ? i_tx_data[16*tx_word +: 16] : `FB_WORD_RESET;
    // Byte 01h is the unused high half of the scan word
    assign tx_sel = (tx_idx == `FB_SCAN_BYTE) ? i_tx_scan_counter
        : (tx_idx == `FB_CTRL_LO_BYTE) ? next_status[7:0]
        : (tx_idx == `FB_CTRL_HI_BYTE) ? next_status[15:8]
        : !in_data(tx_idx, words) ? 8'h00
        : tx_idx[0] ? tx_word_val[15:8] : tx_word_val[7:0];

    // Status word: high byte, bits 4..3 and bit 0 stay zero
    always_comb begin
        next_status = `FB_WORD_RESET;
        next_status[`FB_STAT_ACTIVE_BIT] = lk.active;
        next_status[`FB_STAT_PREPARED_BIT] = lk.prepared;
        next_status[`FB_STAT_TRANSIENT_BIT] = lk.transient;
        next_status[`FB_STAT_CMD_READY_BIT] = !cmd_busy;
        next_status[`FB_STAT_WARNING_BIT] = i_warning;
    end

    // ---------------------------------------------------------------
    // Lockstep controller
    // ---------------------------------------------------------------
    assign lk.conditions_met = i_sync_conditions;
    assign lk.resume_inhibit = o_link_control_word[`FB_CTRL_INHIBIT_BIT];

    lockstep_ctrl #(
        .ENTRY_CYCLES(ENTRY_CYCLES)
    ) u_lockstep (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .lk(lk)
    );

    // ---------------------------------------------------------------
    // Receive: collect a frame, commit it whole at frame end
    // ---------------------------------------------------------------
    // Committing at the end keeps the words of one cycle coherent
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_idx <= 5'h00;
            shadow_scan <= 8'h00;
            shadow_inhibit <= 1'b0;
        end else if (i_clk_en && i_rx_valid) begin
            rx_idx <= (cur_idx == 5'h1f) ? cur_idx : cur_idx + 5'h01;
            if (cur_idx == `FB_SCAN_BYTE) begin
                shadow_scan <= i_rx_byte;
            end
            if (cur_idx == `FB_CTRL_LO_BYTE) begin
                shadow_inhibit <= i_rx_byte[`FB_CTRL_INHIBIT_BIT];
            end
        end
    end

    // One generate lane per data word
    for (genvar w = 0; w < MAX_WORDS; w++) begin : g_word
        always_ff @(posedge i_core_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                shadow_data[w] <= `FB_WORD_RESET;
                rx_data[w] <= `FB_WORD_RESET;
            end else if (i_clk_en) begin
                // Bytes past the frame size are dropped
                if (i_rx_valid && in_data(cur_idx, words) &&
                    rx_word == 4'(w)) begin
                    if (cur_idx[0]) begin
                        shadow_data[w][15:8] <= i_rx_byte;
                    end else begin
                        shadow_data[w][7:0] <= i_rx_byte;
                    end
                end
                if (i_rx_end) begin
                    rx_data[w] <= shadow_data[w];
                end
            end
        end
        assign o_rx_data[16*w +: 16] = rx_data[w];
    end

    // Registers seen by the slave application
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_scan_counter <= `FB_WORD_RESET;
            o_link_control_word <= `FB_WORD_RESET;
            o_slave_status_word <= `FB_WORD_RESET;
        end else if (i_clk_en) begin
            o_slave_status_word <= next_status;
            if (i_rx_end) begin
                // Counter passes through untouched; no check on it
                o_rx_scan_counter <= {8'h00, shadow_scan};
                o_link_control_word <= {15'h0000, shadow_inhibit};
            end
        end
    end

    // ---------------------------------------------------------------
    // Command handshake
    // ---------------------------------------------------------------
    // A new command in the same cycle as a completion wins
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_busy <= 1'b0;
        end else if (i_clk_en) begin
            if (i_cmd_received) begin
                cmd_busy <= 1'b1;
            end else if (i_cmd_done) begin
                cmd_busy <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Transmit: one byte a cycle, scan, status, data
    // ---------------------------------------------------------------
    // A start during a frame is ignored until the last byte is out
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_busy <= 1'b0;
            tx_idx <= 5'h00;
            o_tx_valid <= 1'b0;
            o_tx_last <= 1'b0;
            o_tx_byte <= 8'h00;
        end else if (i_clk_en) begin
            o_tx_valid <= tx_busy;
            o_tx_last <= tx_busy && (tx_idx == last_idx);
            o_tx_byte <= tx_busy ? tx_sel : 8'h00;
            if (tx_busy) begin
                tx_busy <= (tx_idx != last_idx);
                tx_idx <= tx_idx + 5'h01;
            end else if (i_tx_start) begin
                tx_busy <= 1'b1;
                tx_idx <= `FB_SCAN_BYTE;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_cmd_in;
        i_cmd_received;
    endsequence

    sequence s_cmd_out;
        !i_cmd_received && i_cmd_done;
    endsequence

    property p_status_zero;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (o_slave_status_word[15:8] == 8'h00) &&
        (o_slave_status_word[4:3] == 2'b00) && !o_slave_status_word[0];
    endproperty

    a_status_unused_zero: assert property (p_status_zero)
        else $error("Unused status bits not zero");

    a_ctrl_unused_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_link_control_word[15:1] == 15'h0000)
        else $error("Unused control bits not zero");

    a_cmd_busy_shown: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn || !i_clk_en)
        s_cmd_in ##1 !i_cmd_done |=> !o_slave_status_word[2])
        else $error("Command ready not cleared");

    a_cmd_ready_shown: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn || !i_clk_en)
        s_cmd_out ##1 !i_cmd_received |=> o_slave_status_word[2])
        else $error("Command ready not set");

    a_active_tracks: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn || !i_clk_en)
        ##1 (o_slave_status_word[7] == $past(lk.active)))
        else $error("Active flag does not follow lockstep");

    a_scan_first_byte: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn || !i_clk_en)
        (!tx_busy && i_tx_start) ##1 i_tx_scan_counter == $past(
        i_tx_scan_counter) |=> o_tx_valid && o_tx_byte == $past(
        i_tx_scan_counter))
        else $error("Scan counter not first transmit byte");

    a_tx_frame_len: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn || !i_clk_en)
        (!tx_busy && i_tx_start && !i_long_frame) ##1
        !i_long_frame [*8] ##1 !i_long_frame [*8] |=> o_tx_last)
        else $error("Short frame length wrong");

    a_rx_scan_commit: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn || !i_clk_en)
        i_rx_end |=> o_rx_scan_counter == {8'h00, $past(shadow_scan)})
        else $error("Scan counter not committed");
endmodule
`default_nettype wire

/* hdl/fb_io_cfg.svh */
// Frame offsets, status fields, reset values and timing counts.
`ifndef FB_IO_CFG_SVH
`define FB_IO_CFG_SVH

// ---------------------------------------------------------------
// Frame byte layout
// ---------------------------------------------------------------
`define FB_SCAN_BYTE 5'h00
`define FB_CTRL_LO_BYTE 5'h02
`define FB_CTRL_HI_BYTE 5'h03
`define FB_DATA_BASE 5'h04
`define FB_DATA_END_LONG 5'h1d
`define FB_WORDS_SHORT 4'h6
`define FB_WORDS_LONG 4'hd

// ---------------------------------------------------------------
// Register word offsets and fields
// ---------------------------------------------------------------
`define FB_REG_SCAN 4'h0
`define FB_REG_CTRL_STAT 4'h1
`define FB_CTRL_INHIBIT_BIT 0
`define FB_STAT_ACTIVE_BIT 7
`define FB_STAT_PREPARED_BIT 6
`define FB_STAT_TRANSIENT_BIT 5
`define FB_STAT_CMD_READY_BIT 2
`define FB_STAT_WARNING_BIT 1
`define FB_WORD_RESET 16'h0000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define FB_CLK_PERIOD_NS 8
`define FB_ENTRY_NS 1000
`define FB_ENTRY_CYCLES ((`FB_ENTRY_NS + `FB_CLK_PERIOD_NS - 1) / `FB_CLK_PERIOD_NS)

`endif

/* hdl/fb_io_pkg.sv */
// Types shared by the fieldbus slave I/O map.
`default_nettype none
package fb_io_pkg;
    // Lockstep state machine, one-hot codes
    typedef enum logic [2:0] {
        LS_ASYNC = 3'b001,
        LS_ENTERING = 3'b010,
        LS_LOCKED = 3'b100
    } lockstep_state_t;
    typedef logic [15:0] io_word_t;
endpackage
`default_nettype wire

/* hdl/lockstep_if.sv */
// Interface between frame mapper and lockstep controller.
`default_nettype none
interface lockstep_if;
    logic conditions_met; // Synchronisation conditions present
    logic resume_inhibit; // Control word flag from master
    logic active; // Running in lockstep
    logic prepared; // Conditions met and not inhibited
    logic transient; // Entry in progress
    modport ctrl (input conditions_met, input resume_inhibit,
        output active, output prepared, output transient);
    modport user (output conditions_met, output resume_inhibit,
        input active, input prepared, input transient);
endinterface
`default_nettype wire

/* hdl/lockstep_ctrl.sv */
// Lockstep entry, loss and resume control.
`include "fb_io_cfg.svh"
`default_nettype none
module lockstep_ctrl
    import fb_io_pkg::*;
#(
    parameter int ENTRY_CYCLES = `FB_ENTRY_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    lockstep_if.ctrl lk
);
    lockstep_state_t state; // Current lockstep state
    lockstep_state_t next_state; // Next lockstep state
    logic [15:0] entry_cnt; // Cycles spent entering
    logic resume_blocked; // Lost while inhibited
    logic next_blocked; // Next value of resume_blocked
    logic entry_done; // Entry time elapsed
    logic may_enter; // Entry allowed this cycle

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    assign entry_done = (entry_cnt >= 16'(ENTRY_CYCLES - 1));
    // Blocked only until software clears the inhibit again
    assign may_enter = lk.conditions_met && !resume_blocked;
    assign next_blocked = lk.resume_inhibit &&
        (resume_blocked || (state != LS_ASYNC && !lk.conditions_met));
    assign lk.active = (state == LS_LOCKED);
    assign lk.transient = (state == LS_ENTERING);
    // Inhibit pulls the prepared flag down at once
    assign lk.prepared = lk.conditions_met && !lk.resume_inhibit;

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            LS_ASYNC: begin
                if (may_enter) begin
                    next_state = LS_ENTERING;
                end
            end
            LS_ENTERING: begin
                if (!lk.conditions_met) begin
                    next_state = LS_ASYNC;
                end else if (entry_done) begin
                    next_state = LS_LOCKED;
                end
            end
            LS_LOCKED: begin
                if (!lk.conditions_met) begin
                    next_state = LS_ASYNC;
                end
            end
            default: begin
                next_state = LS_ASYNC;
            end
        endcase
    end

    // State, entry counter and block flag
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= LS_ASYNC;
            entry_cnt <= 16'h0000;
            resume_blocked <= 1'b0;
        end else if (i_clk_en) begin
            state <= next_state;
            resume_blocked <= next_blocked;
            entry_cnt <= (state == LS_ENTERING) ? entry_cnt + 16'h0001
                : 16'h0000;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_lost;
        (state == LS_LOCKED) && !lk.conditions_met;
    endsequence

    property p_no_resume;
        @(posedge i_core_clk) disable iff (!i_resetn || !i_clk_en)
        s_lost ##0 lk.resume_inhibit ##1 lk.resume_inhibit [*4]
        |-> (state == LS_ASYNC);
    endproperty

    a_inhibit_stays_async: assert property (p_no_resume)
        else $error("Lockstep resumed while inhibited");

    a_auto_resume: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn || !i_clk_en)
        (state == LS_ASYNC && lk.conditions_met && !resume_blocked)
        |=> (state == LS_ENTERING))
        else $error("Lockstep did not resume automatically");

    a_prepared_inhibit: assert property (
        @(posedge i_core_clk) disable iff (!i_resetn)
        lk.resume_inhibit |-> !lk.prepared)
        else $error("Prepared set while inhibited");
endmodule
`default_nettype wire

/* bench/fb_master_model.sv */
// Master-side model: sends output frames, collects input frames.
`default_nettype none
module fb_master_model (
    input wire logic i_core_clk,
    output logic o_rx_valid,
    output logic o_rx_first,
    output logic [7:0] o_rx_byte,
    output logic o_rx_end,
    output logic o_tx_start,
    input wire logic i_tx_valid,
    input wire logic i_tx_last,
    input wire logic [7:0] i_tx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------
    // Frame buffers
    // ----------------------------------------------------------
    logic [7:0] frame [0:31]; // Bytes to send, index is frame offset
    logic [7:0] got [0:31]; // Bytes collected from the slave
    int got_n; // Count of collected bytes
    logic halted; // Slave counter did not move since last frame
    logic [7:0] last_scan; // Scan byte of the previous input frame

    initial begin
        o_rx_valid = 1'b0;
        o_rx_first = 1'b0;
        o_rx_byte = 8'h00;
        o_rx_end = 1'b0;
        o_tx_start = 1'b0;
        halted = 1'b0;
        last_scan = 8'h00;
        got_n = 0;
    end

    // ----------------------------------------------------------
    // Send n bytes back to back, then commit
    // ----------------------------------------------------------
    task automatic send(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge i_core_clk);
            #1;
            o_rx_valid = 1'b1;
            o_rx_first = (i == 0); // Scan counter byte first
            o_rx_byte = frame[i];
        end
        @(posedge i_core_clk);
        #1;
        o_rx_valid = 1'b0;
        o_rx_first = 1'b0;
        // Released byte lane shows garbage, not the last value
        o_rx_byte = ~o_rx_byte;
        o_rx_end = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_rx_end = 1'b0;
        @(posedge i_core_clk);
        #1;
    endtask

    // ----------------------------------------------------------
    // Request one input frame and collect it
    // ----------------------------------------------------------
    task automatic fetch();
        int k;
        got_n = 0;
        @(posedge i_core_clk);
        #1;
        o_tx_start = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_tx_start = 1'b0;
        for (k = 0; k < 64; k++) begin
            @(posedge i_core_clk);
            #1;
            if (i_tx_valid === 1'b1 && got_n < 32) begin
                got[got_n] = i_tx_byte;
                got_n++;
                if (i_tx_last === 1'b1) begin
                    break;
                end
            end
        end
        // Frozen counter means the slave application paused
        halted = (got[0] === last_scan);
        last_scan = got[0];
        #1;
    endtask
endmodule
`default_nettype wire

/* bench/fieldbus_slave_io_map_tb_top.sv */
// Testbench for the fieldbus slave I/O word mapper.
`default_nettype none
module fieldbus_slave_io_map_tb_top;
    import fb_io_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_clk_en = 1'b1;
    logic i_long_frame = 1'b1;
    logic [7:0] i_tx_scan_counter = 8'h77;
    logic [207:0] i_tx_data;
    logic i_sync_conditions = 1'b0;
    logic i_cmd_received = 1'b0;
    logic i_cmd_done = 1'b0;
    logic i_warning = 1'b0;
    logic rx_valid, rx_first, rx_end, tx_start;
    logic [7:0] rx_byte;
    io_word_t o_rx_scan_counter, o_link_control_word, o_slave_status_word;
    logic [207:0] o_rx_data;
    logic o_tx_valid, o_tx_last;
    logic [7:0] o_tx_byte;
    int errors = 0; // Mismatches seen
    int compares = 0; // Comparisons made
    int w;

    // 125 MHz core clock
    always #4 i_core_clk = ~i_core_clk;

    // Short entry count keeps lockstep runs brief
    fieldbus_slave_io_map #(.MAX_WORDS(13), .ENTRY_CYCLES(4))
        i_fieldbus_slave_io_map (
        .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
        .i_long_frame(i_long_frame), .i_rx_valid(rx_valid),
        .i_rx_first(rx_first), .i_rx_byte(rx_byte), .i_rx_end(rx_end),
        .i_tx_start(tx_start), .i_tx_scan_counter(i_tx_scan_counter),
        .i_tx_data(i_tx_data), .i_sync_conditions(i_sync_conditions),
        .i_cmd_received(i_cmd_received), .i_cmd_done(i_cmd_done),
        .i_warning(i_warning), .o_rx_scan_counter(o_rx_scan_counter),
        .o_link_control_word(o_link_control_word),
        .o_slave_status_word(o_slave_status_word), .o_rx_data(o_rx_data),
        .o_tx_valid(o_tx_valid), .o_tx_last(o_tx_last),
        .o_tx_byte(o_tx_byte));

    fb_master_model i_fb_master_model (
        .i_core_clk(i_core_clk), .o_rx_valid(rx_valid),
        .o_rx_first(rx_first), .o_rx_byte(rx_byte), .o_rx_end(rx_end),
        .o_tx_start(tx_start), .i_tx_valid(o_tx_valid),
        .i_tx_last(o_tx_last), .i_tx_byte(o_tx_byte));

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    task automatic summarize();
        $display("Comparisons %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait for one status bit; timeout ends the run
    task automatic wait_stat(input int b, input logic v, input int n);
        int k;
        compares++;
        for (k = 0; k < n; k++) begin
            if (o_slave_status_word[b] === v) begin
                return;
            end
            @(posedge i_core_clk);
            #1;
        end
        errors++;
        $display("Error status bit %0d expected %b seen %b", b, v,
                 o_slave_status_word[b]);
        summarize();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    // Fill frame: scan, control low/high, data from base bytes
    task automatic build(input logic [7:0] ctl, input logic [7:0] lo,
                         input logic [7:0] hi);
        int j;
        i_fb_master_model.frame[0] = 8'h5a;
        i_fb_master_model.frame[1] = 8'hc3;
        i_fb_master_model.frame[2] = ctl;
        i_fb_master_model.frame[3] = 8'hff;
        for (j = 0; j < 13; j++) begin
            i_fb_master_model.frame[4 + 2 * j] = 8'(lo + j);
            i_fb_master_model.frame[5 + 2 * j] = 8'(hi + j);
        end
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        for (w = 0; w < 13; w++) begin
            i_tx_data[16 * w +: 16] = {8'ha0, 8'(w)};
        end
        tick(20);
        check("status in reset", o_slave_status_word, 16'h0000);
        i_resetn = 1'b1;
        tick(2);
        check("status after reset", o_slave_status_word, 16'h0004);
        // Frozen clock enable: a command pulse must leave no trace
        i_clk_en = 1'b0;
        i_cmd_received = 1'b1;
        tick(1);
        i_cmd_received = 1'b0;
        tick(2);
        i_clk_en = 1'b1;
        tick(2);
        check("frozen cmd", 16'(o_slave_status_word[2]), 16'h0001);
        // Long frame, all control bits set, only the flag survives
        build(8'hff, 8'h40, 8'h80);
        i_fb_master_model.send(30);
        check("scan word", o_rx_scan_counter, 16'h005a);
        check("control word", o_link_control_word, 16'h0001);
        for (w = 0; w < 13; w++) begin
            check("long data", o_rx_data[16 * w +: 16],
                  {8'(8'h80 + w), 8'(8'h40 + w)});
        end
        // Short frame, same scan byte: words past six keep old values
        i_long_frame = 1'b0;
        build(8'h00, 8'h20, 8'h30);
        i_fb_master_model.send(30);
        check("control cleared", o_link_control_word, 16'h0000);
        for (w = 0; w < 13; w++) begin
            check("short data", o_rx_data[16 * w +: 16], (w < 6) ?
                  {8'(8'h30 + w), 8'(8'h20 + w)} :
                  {8'(8'h80 + w), 8'(8'h40 + w)});
        end
        // Input frames, long then short, with warning raised
        i_warning = 1'b1;
        i_long_frame = 1'b1;
        tick(3);
        check("status word", o_slave_status_word, 16'h0006);
        i_fb_master_model.fetch();
        check("long count", 16'(i_fb_master_model.got_n), 16'd30);
        i_long_frame = 1'b0;
        // Moving counter: master must see a running slave
        i_tx_scan_counter = 8'h78;
        i_fb_master_model.fetch();
        check("short count", 16'(i_fb_master_model.got_n), 16'd16);
        check("tx scan", 16'(i_fb_master_model.got[0]), 16'h0078);
        check("tx byte1", 16'(i_fb_master_model.got[1]), 16'h0000);
        check("tx status lo", 16'(i_fb_master_model.got[2]), 16'h0006);
        check("tx status hi", 16'(i_fb_master_model.got[3]), 16'h0000);
        for (w = 0; w < 6; w++) begin
            check("tx data", {i_fb_master_model.got[5 + 2 * w],
                  i_fb_master_model.got[4 + 2 * w]}, {8'ha0, 8'(w)});
        end
        check("run seen", 16'(i_fb_master_model.halted), 16'h0000);
        // Same counter again: master must see a halted slave
        i_fb_master_model.fetch();
        check("halt seen", 16'(i_fb_master_model.halted), 16'h0001);
        i_warning = 1'b0;
        // Command busy, then both pulses in one cycle
        i_cmd_received = 1'b1;
        tick(1);
        i_cmd_received = 1'b0;
        tick(6);
        check("cmd busy", 16'(o_slave_status_word[2]), 16'h0000);
        i_cmd_done = 1'b1;
        tick(1);
        i_cmd_done = 1'b0;
        wait_stat(2, 1'b1, 4);
        i_cmd_received = 1'b1;
        i_cmd_done = 1'b1;
        tick(1);
        i_cmd_received = 1'b0;
        i_cmd_done = 1'b0;
        tick(3);
        check("cmd both", 16'(o_slave_status_word[2]), 16'h0000);
        i_cmd_done = 1'b1;
        tick(1);
        i_cmd_done = 1'b0;
        wait_stat(2, 1'b1, 4);
        // Lockstep entry, loss and automatic resume
        i_sync_conditions = 1'b1;
        wait_stat(5, 1'b1, 4);
        check("prepared", 16'(o_slave_status_word[6]), 16'h0001);
        wait_stat(7, 1'b1, 12);
        check("steady", 16'(o_slave_status_word[5]), 16'h0000);
        i_sync_conditions = 1'b0;
        wait_stat(7, 1'b0, 4);
        check("unprepared", 16'(o_slave_status_word[6]), 16'h0000);
        i_sync_conditions = 1'b1;
        wait_stat(7, 1'b1, 16);
        // Inhibit set, loss, no resume until flag clears
        build(8'h01, 8'h00, 8'h00);
        i_fb_master_model.send(16);
        wait_stat(6, 1'b0, 4);
        i_sync_conditions = 1'b0;
        wait_stat(7, 1'b0, 4);
        i_sync_conditions = 1'b1;
        tick(12);
        check("no resume", 16'(o_slave_status_word[7:5]), 16'h0000);
        build(8'h00, 8'h00, 8'h00);
        i_fb_master_model.send(16);
        wait_stat(7, 1'b1, 16);
        summarize();
    end
endmodule
`default_nettype wire
